// ---- hw/bcef_filter.sv ----
// Event qualification and counting for cache references and queue allocations.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module bcef_filter
   import bcef_pkg::*;
(
   // Clock and reset.
   input  wire logic               mclk_in,
   input  wire logic               resetn_in,
   // Register port.
   input  wire bcef_reg_req_type   reg_req_in,
   output logic [31:0]             rdata_out,
   // Observations from the bus unit and the queue.
   input  wire bcef_cache_obs_type cache_obs_in,
   input  wire bcef_queue_obs_type queue_obs_in,
   // Qualified event pulses.
   output logic                    cache_ref_event_out,
   output logic                    queue_alloc_event_out
);

   // Control registers.
   logic [31:0] cache_sel;
   logic [31:0] queue_sel;
   logic [31:0] next_cache_sel;
   logic [31:0] next_queue_sel;

   // Counters, status and pulses.
   logic [31:0] cache_cnt;
   logic [31:0] queue_cnt;
   logic [1:0]  wrap;
   logic        cache_evt;
   logic        queue_evt;
   logic [31:0] next_cache_cnt;
   logic [31:0] next_queue_cnt;
   logic [1:0]  next_wrap;

   // Read data.
   logic [31:0] rdata;
   logic [31:0] next_rdata;

   // Qualification terms.
   logic [15:0] cmask;
   logic [15:0] qmask;
   logic        c_read;
   logic        c_hit;
   logic        cache_qual;
   logic        rtype_match;
   logic        read_match;
   logic        write_match;
   logic        mem_match;
   logic        agent_match;
   logic        demand_ok;
   logic        queue_qual;

   assign cmask = cache_sel[BCEF_MASK_MSB:BCEF_MASK_LSB];
   assign qmask = queue_sel[BCEF_MASK_MSB:BCEF_MASK_LSB];

   // Cache reference qualification, taken from the attributes as they
   // stand in the cycle of the lookup; a later change of prefetch state
   // or result is not tracked back.
   always_comb begin
      c_read = (cache_obs_in.op == BCEF_OP_LOAD) ||
               (cache_obs_in.op == BCEF_OP_OWN_READ);
      c_hit = 1'b0;
      unique case (cache_obs_in.result)
         BCEF_RES_SHARED: begin
            c_hit = cache_obs_in.level3 ? cmask[BCEF_L3_HIT_S_BIT]
                                        : cmask[BCEF_L2_HIT_S_BIT];
         end
         BCEF_RES_EXCL: begin
            c_hit = cache_obs_in.level3 ? cmask[BCEF_L3_HIT_E_BIT]
                                        : cmask[BCEF_L2_HIT_E_BIT];
         end
         BCEF_RES_MOD: begin
            c_hit = cache_obs_in.level3 ? cmask[BCEF_L3_HIT_M_BIT]
                                        : cmask[BCEF_L2_HIT_M_BIT];
         end
         BCEF_RES_MISS: begin
            c_hit = cache_obs_in.level3 ? cmask[BCEF_L3_MISS_BIT]
                                        : cmask[BCEF_L2_MISS_BIT];
         end
      endcase
      cache_qual = 1'b0;
      if (cache_obs_in.valid && cache_sel[BCEF_ENABLE_BIT]) begin
         if (c_read) begin
            cache_qual = c_hit;
         end else if (cache_obs_in.op == BCEF_OP_WRITEBACK) begin
            cache_qual = !cache_obs_in.level3 &&
                         (cache_obs_in.result == BCEF_RES_MISS) &&
                         cmask[BCEF_WB_MISS_BIT];
         end
      end
   end

   // Queue allocation qualification. Entry size and retry state do not
   // enter the match, so a retried request and a chunk entry each count
   // as one allocation like any other.
   always_comb begin
      rtype_match = (qmask[BCEF_RTYPE_MSB:BCEF_RTYPE_LSB] != 5'h0_0) &&
                    (queue_obs_in.req_type ==
                     qmask[BCEF_RTYPE_MSB:BCEF_RTYPE_LSB]);
      read_match  = qmask[BCEF_ALL_READ_BIT] && queue_obs_in.is_read;
      write_match = qmask[BCEF_ALL_WRITE_BIT] && queue_obs_in.is_write;
      mem_match   = |(qmask[BCEF_MEM_MSB:BCEF_MEM_LSB] &
                      queue_obs_in.mem_type);
      agent_match = (qmask[BCEF_OWN_BIT] && queue_obs_in.own_agent) ||
                    (qmask[BCEF_OTHER_BIT] &&
                     !queue_obs_in.own_agent);
      // Demand-only filter touches reads alone.
      demand_ok   = !(queue_obs_in.is_read && qmask[BCEF_DEMAND_BIT] &&
                      queue_obs_in.prefetch);
      queue_qual  = queue_obs_in.valid && queue_sel[BCEF_ENABLE_BIT] &&
                    (rtype_match || read_match || write_match ||
                     mem_match) && agent_match && demand_ok;
   end

   // Control register group.
   always_comb begin
      next_cache_sel = cache_sel;
      next_queue_sel = queue_sel;
      if (reg_req_in.wr) begin
         if (reg_req_in.addr == BCEF_CACHE_SEL_OFS) begin
            next_cache_sel = reg_req_in.wdata;
         end
         if (reg_req_in.addr == BCEF_QUEUE_SEL_OFS) begin
            next_queue_sel = reg_req_in.wdata;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         cache_sel <= BCEF_SEL_RESET;
         queue_sel <= BCEF_SEL_RESET;
      end else begin
         cache_sel <= next_cache_sel;
         queue_sel <= next_queue_sel;
      end
   end

   // Counter group. A software write to a counter loses to nothing: the
   // written value is taken, and an event in the same cycle adds one to
   // it, so the event is never dropped.
   always_comb begin
      next_cache_cnt = cache_cnt;
      next_queue_cnt = queue_cnt;
      next_wrap      = wrap;
      if (reg_req_in.wr && reg_req_in.addr == BCEF_STATUS_OFS) begin
         next_wrap = wrap & ~reg_req_in.wdata[1:0];
      end
      if (reg_req_in.wr && reg_req_in.addr == BCEF_CACHE_CNT_OFS) begin
         next_cache_cnt = reg_req_in.wdata;
      end
      if (reg_req_in.wr && reg_req_in.addr == BCEF_QUEUE_CNT_OFS) begin
         next_queue_cnt = reg_req_in.wdata;
      end
      if (cache_qual) begin
         if (next_cache_cnt == BCEF_COUNT_MAX) begin
            next_wrap[BCEF_CACHE_WRAP_BIT] = 1'b1;
         end
         next_cache_cnt = next_cache_cnt + BCEF_COUNT_ONE;
      end
      if (queue_qual) begin
         if (next_queue_cnt == BCEF_COUNT_MAX) begin
            next_wrap[BCEF_QUEUE_WRAP_BIT] = 1'b1;
         end
         next_queue_cnt = next_queue_cnt + BCEF_COUNT_ONE;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         cache_cnt <= BCEF_CNT_RESET;
         queue_cnt <= BCEF_CNT_RESET;
         wrap      <= 2'h0;
         cache_evt <= 1'b0;
         queue_evt <= 1'b0;
      end else begin
         cache_cnt <= next_cache_cnt;
         queue_cnt <= next_queue_cnt;
         wrap      <= next_wrap;
         cache_evt <= cache_qual;
         queue_evt <= queue_qual;
      end
   end

   // Read data group; unmapped offsets read as zero.
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            BCEF_CACHE_SEL_OFS: begin
               next_rdata = cache_sel;
            end
            BCEF_QUEUE_SEL_OFS: begin
               next_rdata = queue_sel;
            end
            BCEF_CACHE_CNT_OFS: begin
               next_rdata = cache_cnt;
            end
            BCEF_QUEUE_CNT_OFS: begin
               next_rdata = queue_cnt;
            end
            BCEF_STATUS_OFS: begin
               next_rdata = {30'h0000_0000, wrap};
            end
            default: begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign rdata_out             = rdata;
   assign cache_ref_event_out   = cache_evt;
   assign queue_alloc_event_out = queue_evt;

endmodule : bcef_filter

// ---- pkg/bcef_pkg.sv ----
// Constants and carrier types for the bus cache and queue event filter.
// Notes on behaviour
// - Count L2/L3 references seen at bus unit.
// - Mask in select bits 24:9; hits S/E/M.
// - Mask 8 L2 miss, 9 L3 miss, 10 writeback.
// - Loads and ownership reads both count as reads.
// - Qualify on status as observed now.
// - One count per matching queue allocation.
// - Sector or chunk entry counts once.
// - Each retry attempt counts again.
// - Four mask fields; bits 0-4 request type.
// - Bits 13, 14 select source agent.
// - Bit 15 affects read transactions only.
// - (type or 5 or 6 or mem) and agent.
package bcef_pkg;

   // Register byte offsets.
   localparam logic [7:0] BCEF_CACHE_SEL_OFS  = 8'h00;
   localparam logic [7:0] BCEF_QUEUE_SEL_OFS  = 8'h04;
   localparam logic [7:0] BCEF_CACHE_CNT_OFS  = 8'h08;
   localparam logic [7:0] BCEF_QUEUE_CNT_OFS  = 8'h0C;
   localparam logic [7:0] BCEF_STATUS_OFS     = 8'h10;

   // Field positions inside an event select control register.
   localparam int BCEF_MASK_LSB   = 9;
   localparam int BCEF_MASK_MSB   = 24;
   localparam int BCEF_ENABLE_BIT = 0;

   // Cache reference mask bits.
   localparam int BCEF_L2_HIT_S_BIT = 0;
   localparam int BCEF_L2_HIT_E_BIT = 1;
   localparam int BCEF_L2_HIT_M_BIT = 2;
   localparam int BCEF_L3_HIT_S_BIT = 3;
   localparam int BCEF_L3_HIT_E_BIT = 4;
   localparam int BCEF_L3_HIT_M_BIT = 5;
   localparam int BCEF_L2_MISS_BIT  = 8;
   localparam int BCEF_L3_MISS_BIT  = 9;
   localparam int BCEF_WB_MISS_BIT  = 10;

   // Queue allocation mask fields.
   localparam int BCEF_RTYPE_LSB     = 0;
   localparam int BCEF_RTYPE_MSB     = 4;
   localparam int BCEF_ALL_READ_BIT  = 5;
   localparam int BCEF_ALL_WRITE_BIT = 6;
   localparam int BCEF_MEM_LSB       = 7;
   localparam int BCEF_MEM_MSB       = 11;
   localparam int BCEF_OWN_BIT       = 13;
   localparam int BCEF_OTHER_BIT     = 14;
   localparam int BCEF_DEMAND_BIT    = 15;

   // Status bits and reset values.
   localparam int          BCEF_CACHE_WRAP_BIT = 0;
   localparam int          BCEF_QUEUE_WRAP_BIT = 1;
   localparam logic [31:0] BCEF_SEL_RESET      = 32'h0000_0000;
   localparam logic [31:0] BCEF_CNT_RESET      = 32'h0000_0000;
   localparam logic [31:0] BCEF_COUNT_ONE      = 32'h0000_0001;
   localparam logic [31:0] BCEF_COUNT_MAX      = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      BCEF_OP_LOAD, BCEF_OP_OWN_READ, BCEF_OP_WRITEBACK, BCEF_OP_OTHER
   } bcef_op_type;

   typedef enum logic [1:0] {
      BCEF_RES_SHARED, BCEF_RES_EXCL, BCEF_RES_MOD, BCEF_RES_MISS
   } bcef_result_type;

   // One cache lookup seen at the bus unit.
   typedef struct packed {
      logic            valid;
      logic            level3;
      bcef_op_type     op;
      bcef_result_type result;
      logic            prefetch;
   } bcef_cache_obs_type;

   // One in-order queue allocation; mem_type is one-hot UC,WC,WT,WP,WB.
   typedef struct packed {
      logic       valid;
      logic [4:0] req_type;
      logic       is_read;
      logic       is_write;
      logic [4:0] mem_type;
      logic       own_agent;
      logic       sector;
      logic       retry;
      logic       prefetch;
   } bcef_queue_obs_type;

   // Register port request.
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bcef_reg_req_type;

endpackage : bcef_pkg

// ---- verif/bcef_bus_model.sv ----
// Behavioural bus unit and queue feeding the filter.
`timescale 1ns/10ps
module bcef_bus_model
   import bcef_pkg::*;
(
   // Clock.
   input  wire logic          mclk_in,
   // Observations.
   output bcef_cache_obs_type cache_obs_out,
   output bcef_queue_obs_type queue_obs_out
);
   // Idle cycles clear valid and invert the other fields, so a stale value can never pass for a match.
   initial begin
      cache_obs_out = '0;
      queue_obs_out = '0;
   end
   task send_c(input logic l3, input logic [1:0] op, r, input logic pf);
      @(posedge mclk_in);
      cache_obs_out <= {1'b1, l3, op, r, pf};
      @(posedge mclk_in);
      cache_obs_out <= {1'b0, ~cache_obs_out[5:0]};
   endtask : send_c
   task send_q(input bcef_queue_obs_type o);
      @(posedge mclk_in);
      queue_obs_out <= o;
      @(posedge mclk_in);
      queue_obs_out <= {1'b0, ~queue_obs_out[15:0]};
   endtask : send_q
endmodule : bcef_bus_model

// ---- verif/bcef_filter_monitor.sv ----
// Checker of the event filter ports.
`timescale 1ns/10ps
module bcef_filter_monitor
   import bcef_pkg::*;
(
   // Clock, reset and register port.
   input wire logic               mclk_in,
   input wire logic               resetn_in,
   input wire bcef_reg_req_type   reg_req_in,
   // Observations and pulses.
   input wire bcef_cache_obs_type cache_obs_in,
   input wire bcef_queue_obs_type queue_obs_in,
   input wire logic               cache_ref_event_out,
   input wire logic               queue_alloc_event_out
);
   bcef_reg_req_type   r;
   bcef_cache_obs_type c;
   bcef_queue_obs_type q;
   logic [31:0]        cs, qs, next_cs, next_qs;
   logic [15:0]        cm, qm;
   logic               ch, qh;
   assign r = reg_req_in;
   assign c = cache_obs_in;
   assign q = queue_obs_in;
   assign cm = cs[24:9];
   assign qm = qs[24:9];
   // Select mirrors; an event in the write cycle still sees the old mask.
   always_comb begin
      next_cs = cs;
      next_qs = qs;
      if (r.wr && r.addr == BCEF_CACHE_SEL_OFS) next_cs = r.wdata;
      if (r.wr && r.addr == BCEF_QUEUE_SEL_OFS) next_qs = r.wdata;
   end
   always_ff @(posedge mclk_in) begin
      cs <= resetn_in ? next_cs : '0;
      qs <= resetn_in ? next_qs : '0;
   end
   assign ch = resetn_in && c.valid && cs[0] && (c.op < 2'h2
      ? cm[c.result == BCEF_RES_MISS ? 8 + c.level3 : 3 * c.level3 + c.result]
      : c.op == BCEF_OP_WRITEBACK && !c.level3
        && c.result == BCEF_RES_MISS && cm[10]);
   assign qh = resetn_in && q.valid && qs[0]
      && ((qm[4:0] != 5'h00 && q.req_type == qm[4:0]) || (qm[5] && q.is_read)
         || (qm[6] && q.is_write) || |(qm[11:7] & q.mem_type))
      && ((qm[13] && q.own_agent) || (qm[14] && !q.own_agent))
      && !(q.is_read && qm[15] && q.prefetch);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   chk_cache_match: assert property (ch |=> cache_ref_event_out)
      else $error("cache match without pulse");
   chk_cache_cause: assert property (cache_ref_event_out |-> $past(ch))
      else $error("cache pulse without match");
   chk_cache_other: assert property (c.valid && c.op == BCEF_OP_OTHER
      |=> !cache_ref_event_out) else $error("other op counted");
   chk_queue_match: assert property (qh |=> queue_alloc_event_out)
      else $error("queue match without pulse");
   chk_queue_cause: assert property (queue_alloc_event_out
      |-> $past(qh)) else $error("queue pulse without match");
   chk_queue_agent: assert property (q.valid && !qm[13] && !qm[14]
      |=> !queue_alloc_event_out) else $error("no agent yet counted");
   chk_read_prefetch: assert property (q.valid && q.is_read
      && q.prefetch && qm[15] |=> !queue_alloc_event_out)
      else $error("prefetch read counted");
   chk_retry_counts: assert property (qh && q.retry
      |=> queue_alloc_event_out) else $error("retry not counted");
   cover property (ch);
   cover property (ch && c.op == BCEF_OP_WRITEBACK);
   cover property (qh && q.retry);
   cover property (q.valid && !qh);
endmodule : bcef_filter_monitor
bind bcef_filter bcef_filter_monitor mon_u (.mclk_in, .resetn_in, .reg_req_in,
   .cache_obs_in, .queue_obs_in, .cache_ref_event_out, .queue_alloc_event_out);

// ---- verif/bus_cache_event_filter_tb_top.sv ----
// Self-checking bench of the event filter.
`timescale 1ns/10ps
module bus_cache_event_filter_tb_top import bcef_pkg::*;;
   logic               mclk_in, resetn_in, cev, qev, e;
   bcef_reg_req_type   req;
   logic [31:0]        rdata;
   bcef_cache_obs_type cobs;
   bcef_queue_obs_type qobs;
   int                 bad_count, checks, cyc, n, i;
   int                 ks[9] = '{0, 1, 2, 3, 4, 5, 8, 9, 10};
   bcef_filter dut_u (.mclk_in, .resetn_in, .reg_req_in(req),
      .rdata_out(rdata), .cache_obs_in(cobs), .queue_obs_in(qobs),
      .cache_ref_event_out(cev), .queue_alloc_event_out(qev));
   bcef_bus_model model_u (.mclk_in, .cache_obs_out(cobs),
      .queue_obs_out(qobs));
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   // The run needs about 700 cycles; the ceiling leaves a wide margin.
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         print_verdict();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : check
   task print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk_in);
      req.wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge mclk_in);
      req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
      @(posedge mclk_in);
      req.rd <= 1'b0;
      #1 check(rdata, x);
   endtask : rd
   // Flags f: read, write, own agent, sector, retry, prefetch.
   task q_case(input logic [15:0] m, input logic [4:0] t, mt,
               input logic [5:0] f, input logic x);
      wr(BCEF_QUEUE_SEL_OFS, {7'h00, m, 8'h00, 1'b1});
      model_u.send_q({1'b1, t, f[5:4], mt, f[3:0]});
      #1 check(qev, x);
      n += x;
   endtask : q_case
   // Lookup v holds level, operation and result.
   function automatic logic exp_c(input int k, input logic [4:0] v);
      if (k < 6) return v[3:2] < 2'h2 && v[1:0] != 2'h3
         && v[4] == (k > 2) && v[1:0] == 2'(k % 3);
      if (k < 10) return v[3:2] < 2'h2 && v[1:0] == 2'h3 && v[4] == (k == 9);
      return v[3:2] == 2'h2 && v[1:0] == 2'h3 && !v[4];
   endfunction : exp_c
   initial begin
      resetn_in = 1'b0;
      req = '0;
      repeat (2) @(posedge mclk_in);
      resetn_in <= 1'b1;
      for (i = 0; i < 24; i += 4) rd(8'(i), 32'h0000_0000);
      $display("test reset done");
      foreach (ks[j]) begin
         wr(BCEF_CACHE_SEL_OFS, {7'h00, 16'h0001 << ks[j], 8'h00, 1'b1});
         for (i = 0; i < 32; i++) begin
            e = exp_c(ks[j], i[4:0]);
            model_u.send_c(i[4], i[3:2], i[1:0], i[2]);
            #1 check(cev, e);
            n += e;
         end
      end
      rd(BCEF_CACHE_CNT_OFS, n);
      // The last mask still selects writeback misses, so one such lookup
      // on a full counter must wrap it and raise the cache wrap flag.
      wr(BCEF_CACHE_CNT_OFS, 32'hFFFF_FFFF);
      model_u.send_c(1'b0, 2'h2, 2'h3, 1'b0);
      #1 check(cev, 1'b1);
      rd(BCEF_CACHE_CNT_OFS, 32'h0000_0000);
      rd(BCEF_STATUS_OFS, 32'h0000_0001);
      wr(BCEF_STATUS_OFS, 32'h0000_0001);
      wr(BCEF_CACHE_SEL_OFS, 32'h01FF_FE00);
      model_u.send_c(1'b0, 2'h0, 2'h0, 1'b0);
      #1 check(cev, 1'b0);
      $display("test cache done");
      n = 0;
      q_case(16'h2001, 5'h01, 5'h00, 6'h28, 1'b1);
      q_case(16'h2001, 5'h02, 5'h00, 6'h28, 1'b0);
      q_case(16'h2001, 5'h01, 5'h00, 6'h20, 1'b0);
      q_case(16'h0001, 5'h01, 5'h00, 6'h28, 1'b0);
      q_case(16'h4020, 5'h00, 5'h00, 6'h20, 1'b1);
      q_case(16'h2040, 5'h00, 5'h00, 6'h1C, 1'b1);
      q_case(16'h2080, 5'h00, 5'h01, 6'h08, 1'b1);
      q_case(16'h2100, 5'h00, 5'h01, 6'h08, 1'b0);
      q_case(16'h2100, 5'h00, 5'h02, 6'h0A, 1'b1);
      q_case(16'h2100, 5'h00, 5'h02, 6'h0A, 1'b1);
      q_case(16'hA020, 5'h00, 5'h00, 6'h29, 1'b0);
      q_case(16'hA040, 5'h00, 5'h00, 6'h19, 1'b1);
      q_case(16'h2000, 5'h01, 5'h01, 6'h28, 1'b0);
      rd(BCEF_QUEUE_CNT_OFS, n);
      wr(BCEF_QUEUE_CNT_OFS, 32'hFFFF_FFFF);
      q_case(16'h2001, 5'h01, 5'h00, 6'h28, 1'b1);
      rd(BCEF_QUEUE_CNT_OFS, 32'h0000_0000);
      rd(BCEF_STATUS_OFS, 32'h0000_0002);
      wr(BCEF_STATUS_OFS, 32'h0000_0002);
      rd(BCEF_STATUS_OFS, 32'h0000_0000);
      $display("test queue done");
      print_verdict();
   end
endmodule : bus_cache_event_filter_tb_top
